// File: rtl/wake_edge_detect.sv
/*
  synchronises the active-low wakeup pins and flags each falling edge for one cycle.
  assumes pins are asynchronous to clk_i and idle high.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_edge_detect #(
  parameter int N = 8
) (
  // clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // pins
  input  wire logic [N-1:0] wake_pin_n_i,
  // edge strobes
  wake_evt_if.src           evt
);

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_pin
      logic sync1_reg;
      logic sync2_reg;
      logic prev_reg;

      // reset to the idle level so release of reset is no edge
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sync1_reg <= 1'b1;
          sync2_reg <= 1'b1;
          prev_reg  <= 1'b1;
        end
        else if (ce_i)
        begin
          sync1_reg <= wake_pin_n_i[i];
          sync2_reg <= sync1_reg;
          prev_reg  <= sync2_reg;
        end
      end

      // high then low only: a rising edge never strobes
      assign evt.fall[i] = prev_reg & ~sync2_reg; // R5
    end
  endgenerate

endmodule

`default_nettype wire

// File: rtl/wake_evt_if.sv
/*
  carries the per-pin falling-edge strobes from the pin edge detector to the flag logic.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface wake_evt_if #(parameter int N = 8);
  logic [N-1:0] fall;

  modport src (output fall);
  modport dst (input  fall);
endinterface

`default_nettype wire

// File: rtl/wake_irq_flags.sv
/*
  wakeup and direct-transfer interrupt request flags with a classic wishbone slave,
  a read-to-clear event status register, a mask and one level interrupt output.
  assumes sleep_exec_i and mode_xfer_i come from logic on clk_i; wakeup pins are asynchronous.
*/
// Behaviour
// R1: while the direct-transfer flag is 1, software writing 0 to it clears it.
// R2: the direct-transfer flag is set when a sleep runs with direct transfer enabled and a direct transition happens.
// R3: software may only write 0 to clear a flag; a written 1 is ignored and sets nothing.
// R4: there are eight independent wakeup flags, flag n in bit n for pin n.
// R5: wakeup flag n is set by a falling edge on pin n configured as interrupt input, never by a rising edge.
// R6: writing 0 to bit n clears only wakeup flag n, the other flags keep their values.
// R7: a set event in the same cycle as a clearing write leaves the flag set.
`timescale 1ns/1ps
`default_nettype none
`include "wake_irq_map.svh"

module wake_irq_flags
  import wake_irq_pkg::*;
#(
  parameter int N = `WAKE_PIN_COUNT
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // wakeup pins, active low
  input  wire logic [N-1:0] wake_pin_n_i,
  // sleep and mode transition from the cpu core
  input  wire logic        sleep_exec_i,
  input  wire logic        mode_xfer_i,
  // interrupt
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and events

  logic [N-1:0]             wake_irq_flags_reg;
  logic [N-1:0]             wake_irq_flags_next;
  logic                     direct_xfer_irq_flag_reg;
  logic                     direct_xfer_irq_flag_next;
  logic [N-1:0]             wake_pin_mode_reg;
  logic                     direct_xfer_enable_reg;
  logic [`STAT_WIDTH-1:0]   irq_status_reg;
  logic [`STAT_WIDTH-1:0]   irq_status_next;
  logic [`STAT_WIDTH-1:0]   irq_mask_reg;
  logic                     ack_reg;
  bus_word_t                rdata_reg;
  logic [N-1:0]             wake_set;
  logic                     dx_set;
  reg_sel_e                 reg_sel;
  logic                     req_start;
  logic                     access;
  logic                     wr_lane0;
  logic                     wr_lane1;
  logic [N-1:0]             wake_clr;
  logic                     dx_clr;
  logic [`STAT_WIDTH-1:0]   stat_clr;

  wake_evt_if #(.N(N)) evt ();

  wake_edge_detect #(.N(N)) u_edge (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .wake_pin_n_i (wake_pin_n_i),
    .evt          (evt)
  );

  // only pins configured as interrupt inputs raise their flag
  assign wake_set = evt.fall & wake_pin_mode_reg; // R5
  assign dx_set   = sleep_exec_i & direct_xfer_enable_reg & mode_xfer_i; // R2

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  always_comb
  begin
    unique case (wb_adr_i)
      `OFF_WAKE_IRQ_FLAGS:   reg_sel = SEL_WAKE;
      `OFF_DIRECT_XFER_FLAG: reg_sel = SEL_DXF;
      `OFF_WAKE_PIN_MODE:    reg_sel = SEL_MODE;
      `OFF_DIRECT_XFER_EN:   reg_sel = SEL_DXEN;
      `OFF_IRQ_STATUS:       reg_sel = SEL_STAT;
      `OFF_IRQ_MASK:         reg_sel = SEL_MASK;
      default:               reg_sel = SEL_NONE;
    endcase
  end

  // effects happen at the edge where the master sees ack, so each access acts once
  assign req_start = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign access    = wb_cyc_i & wb_stb_i & ack_reg;
  assign wr_lane0  = access & wb_we_i & wb_sel_i[0];
  assign wr_lane1  = access & wb_we_i & wb_sel_i[1];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else if (ce_i)
      ack_reg <= req_start;
  end

  // read data is snapshotted when the request arrives and stands with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h00000000;
    else if (ce_i && req_start)
    begin
      rdata_reg <= 32'h00000000;
      unique case (reg_sel)
        SEL_WAKE: rdata_reg[N-1:0]                <= wake_irq_flags_reg;
        SEL_DXF:  rdata_reg[`DIRECT_XFER_BIT]     <= direct_xfer_irq_flag_reg;
        SEL_MODE: rdata_reg[N-1:0]                <= wake_pin_mode_reg;
        SEL_DXEN: rdata_reg[`DIRECT_XFER_BIT]     <= direct_xfer_enable_reg;
        SEL_STAT: rdata_reg[`STAT_WIDTH-1:0]      <= irq_status_reg;
        SEL_MASK: rdata_reg[`STAT_WIDTH-1:0]      <= irq_mask_reg;
        SEL_NONE: rdata_reg                       <= 32'h00000000;
      endcase
    end
  end

  assign wb_dat_o = rdata_reg;
  // masked while the enable is low: an ack seen on a frozen edge would lose the write
  assign wb_ack_o = ack_reg & ce_i;

  ////////////////////////////////////////////////////////////////////////////
  // wakeup flags

  // a written 1 clears nothing and sets nothing
  assign wake_clr = (wr_lane0 && reg_sel == SEL_WAKE) ? ~wb_dat_i[N-1:0] : '0; // R3 R6

  always_comb
  begin
    // set wins over clear bit by bit
    wake_irq_flags_next = (wake_irq_flags_reg & ~wake_clr) | wake_set; // R4 R6 R7
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_irq_flags_reg <= `RST_WAKE_IRQ_FLAGS;
    else if (ce_i)
      wake_irq_flags_reg <= wake_irq_flags_next; // R5
  end

  ////////////////////////////////////////////////////////////////////////////
  // direct-transfer flag

  assign dx_clr = wr_lane0 && reg_sel == SEL_DXF && !wb_dat_i[`DIRECT_XFER_BIT]; // R1 R3

  always_comb
  begin
    direct_xfer_irq_flag_next = (direct_xfer_irq_flag_reg & ~dx_clr) | dx_set; // R1 R2 R7
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      direct_xfer_irq_flag_reg <= `RST_DIRECT_XFER_FLAG;
    else if (ce_i)
      direct_xfer_irq_flag_reg <= direct_xfer_irq_flag_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_pin_mode_reg <= `RST_WAKE_PIN_MODE;
    else if (ce_i && wr_lane0 && reg_sel == SEL_MODE)
      wake_pin_mode_reg <= wb_dat_i[N-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      direct_xfer_enable_reg <= `RST_DIRECT_XFER_EN;
    else if (ce_i && wr_lane0 && reg_sel == SEL_DXEN)
      direct_xfer_enable_reg <= wb_dat_i[`DIRECT_XFER_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_reg <= `RST_IRQ_MASK;
    else if (ce_i && reg_sel == SEL_MASK)
    begin
      if (wr_lane0)
        irq_mask_reg[N-1:0] <= wb_dat_i[N-1:0];
      if (wr_lane1)
        irq_mask_reg[`STAT_DIRECT_XFER_BIT] <= wb_dat_i[`STAT_DIRECT_XFER_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status and interrupt

  // only bits that the read returned are cleared, so an event landing between
  // snapshot and ack survives to the next read
  assign stat_clr = (access && !wb_we_i && reg_sel == SEL_STAT) ? rdata_reg[`STAT_WIDTH-1:0] : '0;

  always_comb
  begin
    irq_status_next = (irq_status_reg & ~stat_clr) | {dx_set, wake_set}; // R7
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_status_reg <= `RST_IRQ_STATUS;
    else if (ce_i)
      irq_status_reg <= irq_status_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= |(irq_status_next & irq_mask_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_DX_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    ce_i && dx_clr && !dx_set |=> !direct_xfer_irq_flag_reg)
    else $error("direct-transfer flag not cleared by write of 0");

  AST_DX_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    ce_i && sleep_exec_i && mode_xfer_i && direct_xfer_enable_reg |=> direct_xfer_irq_flag_reg)
    else $error("direct-transfer flag not set after sleep with transfer");

  AST_DX_NO_SPURIOUS: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    !direct_xfer_irq_flag_reg && !(sleep_exec_i && mode_xfer_i && direct_xfer_enable_reg)
    |=> !direct_xfer_irq_flag_reg)
    else $error("direct-transfer flag set without its event");

  AST_WRITE_ONE: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    ce_i && wr_lane0 && reg_sel == SEL_WAKE && wake_set == '0 && wb_dat_i[N-1:0] == '1
    |=> wake_irq_flags_reg == $past(wake_irq_flags_reg))
    else $error("writing ones changed the wakeup flags");

  AST_WAKE_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ce_i && wake_set != '0 |=> (wake_irq_flags_reg & $past(wake_set)) == $past(wake_set))
    else $error("falling edge on an interrupt pin did not set its flag");

  AST_WAKE_STABLE: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    wake_set == '0 && !(wr_lane0 && reg_sel == SEL_WAKE) |=> $stable(wake_irq_flags_reg))
    else $error("wakeup flags changed with no edge and no write");

  AST_WAKE_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    ce_i && wr_lane0 && reg_sel == SEL_WAKE && wake_set == '0
    |=> wake_irq_flags_reg == ($past(wake_irq_flags_reg) & $past(wb_dat_i[N-1:0])))
    else $error("write of 0 did not clear exactly the addressed wakeup flags");

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    ce_i && dx_set && dx_clr |=> direct_xfer_irq_flag_reg)
    else $error("clearing write lost a direct-transfer event");

  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_start |=> ack_reg)
    else $error("request not answered one cycle later");

  AST_ACK_RESET: assert property (@(posedge clk_i)
    rst_i |=> !ack_reg && !irq_o && wb_dat_o == '0)
    else $error("bus answer or interrupt not quiet after reset");

  AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_start && reg_sel == SEL_NONE |=> wb_dat_o == '0)
    else $error("unmapped address returned nonzero data");

  AST_DX_STATUS: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    ce_i && dx_set |=> irq_status_reg[`STAT_DIRECT_XFER_BIT])
    else $error("direct-transfer event missing from status");

  AST_STAT_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && access && !wb_we_i && reg_sel == SEL_STAT && {dx_set, wake_set} == '0
    |=> (irq_status_reg & $past(rdata_reg[`STAT_WIDTH-1:0])) == '0)
    else $error("status read did not clear the returned bits");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> irq_o == |(irq_status_reg & $past(irq_mask_reg)))
    else $error("interrupt output disagrees with masked status");

  AST_CE_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(wake_irq_flags_reg) && $stable(direct_xfer_irq_flag_reg)
    && $stable(irq_status_reg) && $stable(ack_reg) && $stable(irq_o))
    else $error("state changed while the clock enable was low");

endmodule

`default_nettype wire

// File: rtl/wake_irq_map.svh
/*
  register offsets, field positions and reset values of the wakeup flag block.
  assumes byte addresses on a 32-bit classic wishbone bus, one word per register.
*/
`ifndef WAKE_IRQ_MAP_SVH
`define WAKE_IRQ_MAP_SVH

// byte offsets
`define OFF_WAKE_IRQ_FLAGS   8'h00
`define OFF_DIRECT_XFER_FLAG 8'h04
`define OFF_WAKE_PIN_MODE    8'h08
`define OFF_DIRECT_XFER_EN   8'h0C
`define OFF_IRQ_STATUS       8'h10
`define OFF_IRQ_MASK         8'h14

// field layout
`define WAKE_PIN_COUNT       8
`define DIRECT_XFER_BIT      0
`define STAT_DIRECT_XFER_BIT 8
`define STAT_WIDTH           9

// reset values
`define RST_WAKE_IRQ_FLAGS   8'h00
`define RST_DIRECT_XFER_FLAG 1'b0
`define RST_WAKE_PIN_MODE    8'h00
`define RST_DIRECT_XFER_EN   1'b0
`define RST_IRQ_STATUS       9'h000
`define RST_IRQ_MASK         9'h000

`endif

// File: rtl/wake_irq_pkg.sv
/*
  types shared by the wakeup flag block.
  assumes nothing of its surroundings.
*/
package wake_irq_pkg;

  // one-hot register decode
  typedef enum logic [6:0] {
    SEL_NONE = 7'b0000001,
    SEL_WAKE = 7'b0000010,
    SEL_DXF  = 7'b0000100,
    SEL_MODE = 7'b0001000,
    SEL_DXEN = 7'b0010000,
    SEL_STAT = 7'b0100000,
    SEL_MASK = 7'b1000000
  } reg_sel_e;

  typedef logic [31:0] bus_word_t;

endpackage

// File: verif/test_wake_irq_flags.sv
/*
  self-checking bench for the wakeup flag block over classic wishbone.
  assumes the register map header and a one-cycle registered ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_irq_map.svh"

module test_wake_irq_flags;
  import wake_irq_pkg::*;
  logic       clk_i, rst_i, cyc, stb, ce, we, ack, irq, slp, xfr;
  logic [3:0] sel;
  logic [7:0] adr, pins;
  bus_word_t  wdat, rdat, q;
  int         n_errors, n_tests;

  wake_src_model u_src (.clk_i(clk_i), .wake_pin_n_o(pins), .sleep_exec_o(slp), .mode_xfer_o(xfr));

  wake_irq_flags i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wake_pin_n_i(pins), .sleep_exec_i(slp), .mode_xfer_i(xfr), .irq_o(irq));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input bus_word_t seen, input bus_word_t exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until ack is sampled; released only at that edge
  task automatic wb_cycle(input logic w, input logic [7:0] a, input bus_word_t d);
    int k;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (k == 20)
    begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input bus_word_t exp);
    wb_cycle(1'b0, a, 32'h0);
    check(nm, q, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_i);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_errors = 0;
    n_tests  = 0;
    rst_i    = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    ce       = 1'b1;
    sel      = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("flags", `OFF_WAKE_IRQ_FLAGS, 32'h0);
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h0);
    rd_chk("status", `OFF_IRQ_STATUS, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    wb_cycle(1'b1, `OFF_WAKE_PIN_MODE, 32'h0F);
    wb_cycle(1'b1, `OFF_IRQ_MASK, 32'h1FF);
    u_src.drive_pins(8'hFF);
    repeat (3) @(posedge clk_i);
    rd_chk("flags", `OFF_WAKE_IRQ_FLAGS, 32'h0F);
    irq_chk(1'b1);
    u_src.drive_pins(8'h00);
    repeat (3) @(posedge clk_i);
    rd_chk("status", `OFF_IRQ_STATUS, 32'h0F);
    irq_chk(1'b0);
    rd_chk("status", `OFF_IRQ_STATUS, 32'h0);
    wb_cycle(1'b1, `OFF_WAKE_IRQ_FLAGS, 32'hFE);
    rd_chk("flags", `OFF_WAKE_IRQ_FLAGS, 32'h0E);
    wb_cycle(1'b1, `OFF_WAKE_IRQ_FLAGS, 32'h00);
    rd_chk("flags", `OFF_WAKE_IRQ_FLAGS, 32'h0);
    wb_cycle(1'b1, `OFF_WAKE_PIN_MODE, 32'hFF);
    wb_cycle(1'b1, `OFF_IRQ_MASK, 32'h000);
    u_src.drive_pins(8'h80);
    repeat (3) @(posedge clk_i);
    rd_chk("flags", `OFF_WAKE_IRQ_FLAGS, 32'h80);
    irq_chk(1'b0);
    wb_cycle(1'b1, `OFF_IRQ_MASK, 32'h080);
    irq_chk(1'b1);
    rd_chk("status", `OFF_IRQ_STATUS, 32'h080);
    u_src.drive_pins(8'h00);
    // direct transfer: enable off, then no transition, then both present
    u_src.sleep_pulse(1'b1);
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h0);
    wb_cycle(1'b1, `OFF_DIRECT_XFER_EN, 32'h1);
    u_src.sleep_pulse(1'b0);
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h0);
    u_src.sleep_pulse(1'b1);
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h1);
    rd_chk("status", `OFF_IRQ_STATUS, 32'h100);
    wb_cycle(1'b1, `OFF_DIRECT_XFER_FLAG, 32'hFFFFFFFF);
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h1);
    wb_cycle(1'b1, `OFF_DIRECT_XFER_FLAG, 32'h0);
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h0);
    // set event lands on the very edge where the clearing write takes effect
    fork
      wb_cycle(1'b1, `OFF_DIRECT_XFER_FLAG, 32'h0);
      begin
        @(posedge clk_i);
        u_src.sleep_pulse(1'b1);
      end
    join
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h1);
    // a write with the low byte lane off clears nothing
    sel <= 4'h2;
    wb_cycle(1'b1, `OFF_WAKE_IRQ_FLAGS, 32'h00);
    sel <= 4'hF;
    rd_chk("flags", `OFF_WAKE_IRQ_FLAGS, 32'h80);
    // enable low: a pin pulse goes unseen and the bus answer waits for the enable
    ce <= 1'b0;
    u_src.drive_pins(8'h01);
    u_src.drive_pins(8'h00);
    fork
      wb_cycle(1'b1, `OFF_DIRECT_XFER_FLAG, 32'h0);
      begin
        repeat (4) @(posedge clk_i);
        ce <= 1'b1;
      end
    join
    rd_chk("flags", `OFF_WAKE_IRQ_FLAGS, 32'h80);
    rd_chk("dxf", `OFF_DIRECT_XFER_FLAG, 32'h0);
    wrap_up();
  end
endmodule

`default_nettype wire

// File: verif/wake_src_model.sv
/*
  far-side model: the eight wakeup pins and the core's sleep and mode-transition strobes.
  assumes one clock shared with the block; pins have pull-ups, so they idle high.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_src_model (
  // clock
  input  wire logic       clk_i,
  // pins and core strobes
  output logic      [7:0] wake_pin_n_o,
  output logic            sleep_exec_o,
  output logic            mode_xfer_o
);
  initial
  begin
    wake_pin_n_o = 8'hFF;
    sleep_exec_o = 1'b0;
    mode_xfer_o  = 1'b0;
  end

  // a pin level is held three cycles so the two-flop synchroniser surely sees it
  task automatic drive_pins(input logic [7:0] low_mask);
    @(posedge clk_i);
    wake_pin_n_o <= ~low_mask;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic sleep_pulse(input logic xfer);
    @(posedge clk_i);
    sleep_exec_o <= 1'b1;
    mode_xfer_o  <= xfer;
    @(posedge clk_i);
    sleep_exec_o <= 1'b0;
    mode_xfer_o  <= 1'b0;
  endtask
endmodule

`default_nettype wire
